/* File: test/tb_wpr_regs.sv */
/*
  self-checking bench for wpr_regs.
  assumes wpr_pkg and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h, expected %h", $time, g, e); end end
module tb_wpr_regs;
  import wpr_pkg::*;
  logic        clk = 0, sys_rst = 1, acc_we, imm_refused;
  exec_req_t   req = '{OP_NONE, PTR_FIRST, 1'b0, 8'h00, 8'h00};
  ram_req_t    ram_req;
  logic [7:0]  acc = 0, ram_rdata = 0, acc_wdata, d, a, e;
  logic [7:0]  loc_ptr, bank_ptr, result_reg, loc2_ptr, bank2_ptr, ext_reg;
  logic [15:0] rom_word = 0;
  logic [23:0] rom_addr;
  logic [47:0] exp_r = '0;
  int          fails = 0, compares = 0, cyc = 0;
  wire  [47:0] regs = {ext_reg, bank2_ptr, loc2_ptr, result_reg, bank_ptr, loc_ptr};
  always #5 clk = ~clk;
  wpr_regs u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .acc(acc), .ram_rdata(ram_rdata),
    .rom_word(rom_word), .ram_req(ram_req), .rom_addr(rom_addr), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .imm_refused(imm_refused), .loc_ptr(loc_ptr),
    .bank_ptr(bank_ptr), .result_reg(result_reg), .loc2_ptr(loc2_ptr),
    .bank2_ptr(bank2_ptr), .ext_reg(ext_reg));
  function automatic logic [23:0] rom_exp();
    return exp_r[47:24];
  endfunction : rom_exp
  task automatic go(input wpr_op_t o, input ptr_sel_t p, input logic t,
                    input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    #1 req = '{o, p, t, ad, dt};
    #1;
  endtask : go
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h7B18));
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    `CHK({acc_we, ext_reg}, 9'h000)
    repeat (20) begin
      for (int i = 0; i < 6; i++) begin
        d = 8'($urandom);
        exp_r[i*8+:8] = d;
        go(OP_IMM, PTR_FIRST, 1'b0, 8'h80 + 8'(i), d);
        `CHK(imm_refused, 1'b0)
      end
      a = 8'($urandom);
      if (a inside {[8'h80:8'h87]}) a = 8'h88;
      go(OP_IMM, PTR_FIRST, 1'b0, a, 8'($urandom));
      `CHK(imm_refused, 1'b1)
      go(OP_IMM, PTR_FIRST, 1'b1, 8'h00, d);
      `CHK(regs, exp_r)
      rom_word = 16'($urandom);
      go(OP_LOOKUP, PTR_FIRST, 1'b0, 8'h00, 8'h00);
      `CHK({acc_we, acc_wdata}, {1'b1, d})
      `CHK(rom_addr, rom_exp())
      exp_r[23:16] = rom_word[15:8];
      acc = 8'($urandom);
      a = 8'($urandom) & 8'h7F;
      go(OP_DIR_STORE, PTR_FIRST, 1'b0, a, 8'h00);
      `CHK(ram_req, {1'b1, 8'h00, a, acc})
      `CHK({acc_we, acc_wdata, result_reg}, {1'b1, rom_word[7:0], rom_word[15:8]})
      ram_rdata = 8'($urandom);
      go(OP_DIR_LOAD, PTR_FIRST, 1'b0, a, 8'h00);
      d = 8'($urandom);
      exp_r[15:8] = d;
      go(OP_IMM, PTR_FIRST, 1'b0, 8'h81, d);
      `CHK({acc_we, acc_wdata}, {1'b1, ram_rdata})
      e = 8'($urandom);
      go(OP_IND_STORE, PTR_FIRST, 1'b0, 8'h00, e);
      `CHK(ram_req, {1'b1, d, exp_r[7:0], e})
      d = 8'($urandom);
      exp_r[39:32] = d;
      go(OP_IMM, PTR_FIRST, 1'b0, 8'h84, d);
      ram_rdata = 8'($urandom);
      go(OP_IND_LOAD, PTR_SECOND, 1'b0, 8'h00, 8'h00);
      `CHK({ram_req.we, ram_req.bank, ram_req.addr}, {1'b0, d, exp_r[31:24]})
      go(OP_IND_STORE, PTR_SECOND, 1'b0, 8'h00, e);
      `CHK({acc_we, acc_wdata}, {1'b1, ram_rdata})
      `CHK(ram_req, {1'b1, d, exp_r[31:24], e})
      go(OP_DIR_STORE, PTR_FIRST, 1'b0, 8'h82, 8'h00);
      `CHK(ram_req.we, 1'b0)
      `CHK(regs, exp_r)
      exp_r[23:16] = acc;
      go(OP_DIR_LOAD, PTR_FIRST, 1'b0, 8'h82, 8'h00);
      `CHK(result_reg, acc)
      go(OP_NONE, PTR_FIRST, 1'b0, 8'h00, 8'h00);
      `CHK({acc_we, acc_wdata}, {1'b1, acc})
      `CHK(regs, exp_r)
    end
    wrap_up();
  end
endmodule : tb_wpr_regs

/* File: test/wpr_regs_chk.sv */
/*
  port assertions for wpr_regs.
  assumes wpr_pkg is compiled first; bound to every wpr_regs instance.
*/
`timescale 1ns/1ps
module wpr_regs_chk import wpr_pkg::*; (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        acc_we,
  input wire logic        imm_refused,
  input wire exec_req_t   req,
  input wire ram_req_t    ram_req,
  input wire logic [15:0] rom_word,
  input wire logic [23:0] rom_addr,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  acc_wdata,
  input wire logic [7:0]  loc_ptr,
  input wire logic [7:0]  bank_ptr,
  input wire logic [7:0]  result_reg,
  input wire logic [7:0]  loc2_ptr,
  input wire logic [7:0]  bank2_ptr,
  input wire logic [7:0]  ext_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic ist = req.op == OP_IND_STORE;
  wire logic imw = req.op == OP_IMM && !req.imm_to_acc;
  a_ext_reset: assert property ($fell(sys_rst) |-> ext_reg == 8'h00 && !acc_we)
    else $error("ext not cleared");
  a_first_ptr: assert property (ist && req.ptr == PTR_FIRST |-> ram_req.we &&
    ram_req.bank == bank_ptr && ram_req.addr == loc_ptr) else $error("first pointer");
  a_second_ptr: assert property (ist && req.ptr == PTR_SECOND |-> ram_req.we &&
    ram_req.bank == bank2_ptr && ram_req.addr == loc2_ptr) else $error("second pointer");
  a_ptr_kept: assert property (ist |=> $stable({loc_ptr, bank_ptr, loc2_ptr, bank2_ptr}))
    else $error("pointer changed");
  a_lookup_split: assert property (req.op == OP_LOOKUP |=> acc_we &&
    result_reg == $past(rom_word[15:8]) && acc_wdata == $past(rom_word[7:0]))
    else $error("lookup split");
  a_rom_ptr: assert property (req.op == OP_LOOKUP |->
    rom_addr == {ext_reg, bank2_ptr, loc2_ptr}) else $error("rom address");
  a_imm_refuse: assert property (imw && !(req.addr inside {[8'h80:8'h87]}) |->
    imm_refused ##1 !acc_we) else $error("immediate not refused");
  a_imm_bank: assert property (imw && req.addr == 8'h81 |=> bank_ptr == $past(req.data))
    else $error("bank pointer write");
  a_dir_store: assert property (req.op == OP_DIR_STORE && req.addr < 8'h80 |->
    ram_req == {1'b1, 8'h00, req.addr, acc}) else $error("direct store");
endmodule : wpr_regs_chk
bind wpr_regs wpr_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .acc_we(acc_we),
  .imm_refused(imm_refused), .req(req), .ram_req(ram_req), .rom_word(rom_word),
  .rom_addr(rom_addr), .acc(acc), .acc_wdata(acc_wdata), .loc_ptr(loc_ptr),
  .bank_ptr(bank_ptr), .result_reg(result_reg), .loc2_ptr(loc2_ptr),
  .bank2_ptr(bank2_ptr), .ext_reg(ext_reg));

/* File: verilog/wpr_consts.svh */
/*
  offsets, reset values and field positions for the working pointer registers.
  assumes inclusion by bare name from the package and the modules.
*/
`ifndef WPR_CONSTS_SVH
`define WPR_CONSTS_SVH
`define WPR_OFS_LOC      8'h80
`define WPR_OFS_BANK     8'h81
`define WPR_OFS_RES      8'h82
`define WPR_OFS_LOC2     8'h83
`define WPR_OFS_BANK2    8'h84
`define WPR_OFS_EXT      8'h85
`define WPR_OFS_IMM_LO   8'h80
`define WPR_OFS_IMM_HI   8'h87
`define WPR_EXT_RST      8'h00
`define WPR_DATA_W       8
`define WPR_ROMW_HI      15
`define WPR_ROMW_LO_TOP  7
`endif

/* File: verilog/wpr_pkg.sv */
/*
  types shared by the working pointer register block.
  assumes wpr_consts.svh is on the include path.
*/
`include "wpr_consts.svh"
package wpr_pkg;
  typedef enum logic [6:0] {
    OP_NONE      = 7'b0000001,
    OP_IMM       = 7'b0000010,
    OP_DIR_LOAD  = 7'b0000100,
    OP_DIR_STORE = 7'b0001000,
    OP_IND_LOAD  = 7'b0010000,
    OP_IND_STORE = 7'b0100000,
    OP_LOOKUP    = 7'b1000000
  } wpr_op_t;

  typedef enum logic [1:0] {
    PTR_FIRST  = 2'b01,
    PTR_SECOND = 2'b10
  } ptr_sel_t;

  typedef struct packed {
    wpr_op_t  op;
    ptr_sel_t ptr;
    logic     imm_to_acc;
    logic [7:0] addr;
    logic [7:0] data;
  } exec_req_t;

  typedef struct packed {
    logic       we;
    logic [7:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ram_req_t;
endpackage : wpr_pkg

/* File: verilog/wpr_ptr_mux.sv */
/*
  selects the pointer pair used by an indirect operand.
  assumes pointer values are the registered ones of the current cycle.
*/
`timescale 1ns/1ps
module wpr_ptr_mux (
  input  wire wpr_pkg::ptr_sel_t sel,
  input  wire logic [7:0]        bank1,
  input  wire logic [7:0]        loc1,
  input  wire logic [7:0]        bank2,
  input  wire logic [7:0]        loc2,
  output logic [7:0]             bank,
  output logic [7:0]             loc
);
  import wpr_pkg::*;
  always_comb begin
    if (sel == PTR_SECOND) begin
      bank = bank2; // RULE_04
      loc  = loc2;
    end else begin
      bank = bank1; // RULE_02
      loc  = loc1;
    end
  end
endmodule : wpr_ptr_mux

/* File: verilog/wpr_regs.sv */
/*
  working pointer registers and the operand addressing they serve.
  assumes one instruction request per cycle from the core, synchronous ram
  write port, and rom word supplied alongside a table look-up request.
*/
// Operation
// RULE_01: bank and location pointers, undefined reset
// RULE_02: first indirect uses bank and location
// RULE_03: second pair registers, undefined reset
// RULE_04: second indirect uses second pair
// RULE_05: second pair: storage, ram, rom pointer
// RULE_06: extension register, resets zero, rom pointer
// RULE_07: result register, undefined after reset
// RULE_08: look-up: upper to result, lower accumulator
// RULE_09: immediate targets accumulator or 0x80-0x87
// RULE_10: direct moves accumulator to/from ram
// RULE_11: indirect writes hit ram, not pointers
// RULE_12: indirect uses pointers of instruction start
`timescale 1ns/1ps
`include "wpr_consts.svh"
module wpr_regs (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire wpr_pkg::exec_req_t req,
  input  wire logic [7:0]        acc,
  input  wire logic [7:0]        ram_rdata,
  input  wire logic [15:0]       rom_word,
  output wpr_pkg::ram_req_t      ram_req,
  output logic [23:0]            rom_addr,
  output logic                   acc_we,
  output logic [7:0]             acc_wdata,
  output logic                   imm_refused,
  output logic [7:0]             loc_ptr,
  output logic [7:0]             bank_ptr,
  output logic [7:0]             result_reg,
  output logic [7:0]             loc2_ptr,
  output logic [7:0]             bank2_ptr,
  output logic [7:0]             ext_reg
);
  import wpr_pkg::*;

  // architectural registers of the system area
  logic [7:0] ram_location_pointer_ff;
  logic [7:0] ram_bank_pointer_ff;
  logic [7:0] lookup_upper_result_ff;
  logic [7:0] second_location_pointer_ff;
  logic [7:0] second_bank_pointer_ff;
  logic [7:0] rom_pointer_extension_ff;

  // accumulator write-back, one cycle behind the instruction
  logic [7:0] acc_wdata_ff;
  logic       acc_we_ff;

  // indirect pointer pair and register-space write path
  logic [7:0] ind_bank;
  logic [7:0] ind_loc;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // working register window of the system area
  function automatic logic is_work_reg(input logic [7:0] a);
    is_work_reg = (a >= `WPR_OFS_IMM_LO) && (a <= `WPR_OFS_IMM_HI);
  endfunction : is_work_reg

  // write strobe for one register offset
  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction : wr_hit

  // register-space read, unused offsets read zero
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      `WPR_OFS_LOC:   reg_read = ram_location_pointer_ff;
      `WPR_OFS_BANK:  reg_read = ram_bank_pointer_ff;
      `WPR_OFS_RES:   reg_read = lookup_upper_result_ff;
      `WPR_OFS_LOC2:  reg_read = second_location_pointer_ff;
      `WPR_OFS_BANK2: reg_read = second_bank_pointer_ff;
      `WPR_OFS_EXT:   reg_read = rom_pointer_extension_ff;
      default:        reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // pointers taken straight from the registers, so a prior update is seen
  wpr_ptr_mux u_ptr_mux (
    .sel   (req.ptr),
    .bank1 (ram_bank_pointer_ff),
    .loc1  (ram_location_pointer_ff),
    .bank2 (second_bank_pointer_ff),
    .loc2  (second_location_pointer_ff),
    .bank  (ind_bank),
    .loc   (ind_loc)
  ); // RULE_12

  // register-space write source: immediate to working reg or direct store
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = req.addr;
    wr_data = req.data;
    if (req.op == OP_IMM && !req.imm_to_acc && is_work_reg(req.addr)) begin
      wr_en = 1'b1; // RULE_09
    end else if (req.op == OP_DIR_STORE && is_work_reg(req.addr)) begin
      wr_en   = 1'b1; // RULE_10
      wr_data = acc;
    end
  end

  // immediate aimed outside the working window is dropped
  assign imm_refused = (req.op == OP_IMM) &&
                       !req.imm_to_acc &&
                       !is_work_reg(req.addr); // RULE_09

  // first pair: location pointer, no reset value
  always_ff @(posedge clk) begin
    if (wr_hit(wr_en, wr_addr, `WPR_OFS_LOC)) begin
      ram_location_pointer_ff <= wr_data; // RULE_01
    end
  end

  // first pair: bank pointer, no reset value
  always_ff @(posedge clk) begin
    if (wr_hit(wr_en, wr_addr, `WPR_OFS_BANK)) begin
      ram_bank_pointer_ff <= wr_data; // RULE_01
    end
  end

  // second pair: location pointer, no reset value
  always_ff @(posedge clk) begin
    if (wr_hit(wr_en, wr_addr, `WPR_OFS_LOC2)) begin
      second_location_pointer_ff <= wr_data; // RULE_03
    end
  end

  // second pair: bank pointer, also middle rom pointer byte
  always_ff @(posedge clk) begin
    if (wr_hit(wr_en, wr_addr, `WPR_OFS_BANK2)) begin
      second_bank_pointer_ff <= wr_data; // RULE_05
    end
  end

  // result register: look-up upper byte or plain write
  always_ff @(posedge clk) begin
    if (req.op == OP_LOOKUP) begin
      lookup_upper_result_ff <= rom_word[`WPR_ROMW_HI:`WPR_ROMW_LO_TOP+1]; // RULE_08
    end else if (wr_hit(wr_en, wr_addr, `WPR_OFS_RES)) begin
      lookup_upper_result_ff <= wr_data; // RULE_07
    end
  end

  // extension register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rom_pointer_extension_ff <= `WPR_EXT_RST; // RULE_06
    end else if (wr_hit(wr_en, wr_addr, `WPR_OFS_EXT)) begin
      rom_pointer_extension_ff <= wr_data; // RULE_06
    end
  end

  // accumulator write-back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_we_ff    <= 1'b0;
      acc_wdata_ff <= 8'h00;
    end else begin
      acc_we_ff <= 1'b0;
      unique case (req.op)
        OP_IMM: begin
          acc_we_ff    <= req.imm_to_acc; // RULE_09
          acc_wdata_ff <= req.data;
        end
        // working registers read back, the rest from ram
        OP_DIR_LOAD: begin
          acc_we_ff    <= 1'b1; // RULE_10
          acc_wdata_ff <= is_work_reg(req.addr) ? reg_read(req.addr) : ram_rdata;
        end
        OP_IND_LOAD: begin
          acc_we_ff    <= 1'b1;
          acc_wdata_ff <= ram_rdata;
        end
        OP_LOOKUP: begin
          acc_we_ff    <= 1'b1;
          acc_wdata_ff <= rom_word[`WPR_ROMW_LO_TOP:0]; // RULE_08
        end
        OP_NONE, OP_DIR_STORE, OP_IND_STORE: begin
          acc_we_ff <= 1'b0;
        end
        default: acc_we_ff <= 1'b0;
      endcase
    end
  end

  // ram port: indirect address from pointer pair, direct from instruction
  always_comb begin
    ram_req.we    = 1'b0;
    // direct ram access is fixed to bank 0
    ram_req.bank  = 8'h00;
    ram_req.addr  = req.addr;
    ram_req.wdata = acc;
    if (req.op == OP_IND_LOAD || req.op == OP_IND_STORE) begin
      ram_req.bank  = ind_bank; // RULE_02
      ram_req.addr  = ind_loc; // RULE_04
      ram_req.we    = (req.op == OP_IND_STORE); // RULE_11
      ram_req.wdata = req.data;
    end else if (req.op == OP_DIR_STORE && !is_work_reg(req.addr)) begin
      ram_req.we = 1'b1; // RULE_10
    end
  end

  // rom pointer for table look-up, extension as the top byte
  assign rom_addr   = {rom_pointer_extension_ff,
                       second_bank_pointer_ff,
                       second_location_pointer_ff}; // RULE_05

  // register contents straight out
  assign acc_we     = acc_we_ff;
  assign acc_wdata  = acc_wdata_ff;
  assign loc_ptr    = ram_location_pointer_ff;
  assign bank_ptr   = ram_bank_pointer_ff;
  assign result_reg = lookup_upper_result_ff;
  assign loc2_ptr   = second_location_pointer_ff;
  assign bank2_ptr  = second_bank_pointer_ff;
  assign ext_reg    = rom_pointer_extension_ff;
endmodule : wpr_regs
